// ==== hw/cibc_map.svh ====
// address map, vector locations and timing counts of the interrupt and bus control block
`ifndef CIBC_MAP_SVH
`define CIBC_MAP_SVH

`define CIBC_VEC_NMI       16'hFFEC
`define CIBC_VEC_RST       16'hFFEE
`define CIBC_VEC_ROW       16'hFFF8
`define CIBC_VEC_EXT       16'hFFFA
`define CIBC_VEC_TMR       16'hFFFC
`define CIBC_VEC_BRK       16'hFFFE
`define CIBC_VEC_HI_BIT    16'h0001
`define CIBC_ROM_BASE      16'hF800
`define CIBC_RAM_BASE      16'h0080
`define CIBC_RAM_MASK      16'hFFC0
`define CIBC_IO_BASE       16'h0000
`define CIBC_IO_MASK       16'hFFF0
`define CIBC_STACK_PAGE    8'h01
`define CIBC_BRK_FLAG      8'h10
`define CIBC_INIT_CYCLES   3'h6
`define CIBC_CLK_PERIOD_NS 5
`define CIBC_BUS_CYCLE_NS  1000
`define CIBC_QUARTER_CYC   ((`CIBC_BUS_CYCLE_NS / `CIBC_CLK_PERIOD_NS) / 4)

`endif

// ==== hw/cibc_pkg.sv ====
// types shared by the interrupt and bus control block
package cibc_pkg;

  typedef enum logic [2:0] {
    ST_RESET    = 3'b000,
    ST_INIT     = 3'b001,
    ST_RUN      = 3'b010,
    ST_PUSH_PCH = 3'b011,
    ST_PUSH_PCL = 3'b100,
    ST_PUSH_PSR = 3'b101,
    ST_VEC_LO   = 3'b110,
    ST_VEC_HI   = 3'b111
  } cibc_state_t;

  typedef struct packed {
    logic nmi;
    logic row;
    logic ext;
    logic tmr;
  } cibc_irq_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rw;
  } cibc_cycle_t;

endpackage

// ==== hw/cibc_phase_gen.sv ====
// bus phase clock generator: divides clk into four quarters per bus cycle
`timescale 1ns/1ps
`default_nettype none
`include "cibc_map.svh"

module cibc_phase_gen
  import cibc_pkg::*;
#(
  parameter int unsigned QUARTER = `CIBC_QUARTER_CYC
) (
  input  wire logic clk,
  input  wire logic reset_n,
  output var  logic phase2_ff,
  output var  logic phase4_ff,
  output wire logic cycle_end,
  output wire logic phase2_rise
);

  logic [15:0] div_ff;
  logic [1:0]  qtr_ff;

  wire       quarter_tick = (div_ff == 16'(QUARTER - 1));
  wire [1:0] nxt_qtr      = quarter_tick ? 2'(qtr_ff + 2'h1) : qtr_ff;

  // phase two falls at the end of the last quarter, which closes a bus cycle
  assign cycle_end   = quarter_tick && (qtr_ff == 2'h3);
  assign phase2_rise = quarter_tick && (qtr_ff == 2'h1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_ff    <= 16'h0000;
      qtr_ff    <= 2'h0;
      phase2_ff <= 1'b0;
      phase4_ff <= 1'b0;
    end else begin
      div_ff    <= quarter_tick ? 16'h0000 : 16'(div_ff + 16'h0001);
      qtr_ff    <= nxt_qtr;
      phase2_ff <= nxt_qtr[1];
      phase4_ff <= nxt_qtr[1] ^ nxt_qtr[0];
    end
  end

endmodule
`default_nettype wire

// ==== hw/cibc_irq_ctl.sv ====
// interrupt request lines: open-drain drive, request decode and edge capture
`timescale 1ns/1ps
`default_nettype none
`include "cibc_map.svh"

module cibc_irq_ctl
  import cibc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          irq_a_level,
  input  wire logic          irq_b_level,
  input  wire logic          nmi_level_n,
  input  wire logic          row_rx_src,
  input  wire logic          timer_src,
  input  wire logic          nmi_taken,
  output var  logic          irq_line_a_oe,
  output var  logic          irq_line_b_oe,
  output wire cibc_irq_req_t req,
  output wire logic [15:0]   mask_vec
);

  logic nmi_prev_ff;
  logic nmi_pend_ff;

  // the pins are read back, so an external source pulling the same line merges in
  wire a_low    = !irq_a_level;
  wire b_low    = !irq_b_level;
  wire nmi_fall = nmi_prev_ff && !nmi_level_n;

  assign req.row  = a_low && b_low;
  assign req.ext  = b_low && !a_low;
  assign req.tmr  = a_low && !b_low;
  assign req.nmi  = nmi_pend_ff;
  assign mask_vec = req.row ? `CIBC_VEC_ROW :
                    req.ext ? `CIBC_VEC_EXT : `CIBC_VEC_TMR;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_line_a_oe <= 1'b0;
      irq_line_b_oe <= 1'b0;
      nmi_prev_ff   <= 1'b1;
      nmi_pend_ff   <= 1'b0;
    end else begin
      // only ever pull low, never drive high, so outside sources can share the wire
      irq_line_a_oe <= row_rx_src || timer_src;
      irq_line_b_oe <= row_rx_src;
      nmi_prev_ff   <= nmi_level_n;
      // a new edge in the cycle it is taken stays pending; a held low adds nothing
      nmi_pend_ff   <= nmi_fall || (nmi_pend_ff && !nmi_taken);
    end
  end

endmodule
`default_nettype wire

// ==== hw/cibc_top.sv ====
// interrupt entry, reset start-up and pin-level bus control around the cpu core
//
// What this block does
// - request lines are sampled; unmasked requests enter at an instruction boundary.
// - entry pushes program counter and status, sets mask, loads vector.
// - maskable requests are levels; nothing is latched while masked.
// - two request lines decode to row, external and timer vectors; break separate.
// - row source pulls both request lines, timer source pulls only the first.
// - a falling edge on the non-maskable input always enters via its vector.
// - the non-maskable input is edge sensitive; a held low does nothing more.
// - bus enable high drives read/write; low reverses buses for an outside master.
// - in test mode the top two kilobytes may be moved to external memory.
// - ready low while phase two is low halts the cycle until ready returns.
// - the lock output is low during modify and write cycles of such instructions.
// - the lock output replaces the third port D line only when optioned.
// - with bus enable high a 16-bit address bus is driven outward.
// - with bus enable high and the three-state bit set outside test mode, address, data and read/write are pulled low weakly.
// - with bus enable low the incoming address feeds the internal decoder.
// - an 8-bit two-way data bus carries all external exchanges.
// - two active-high phase clocks time the bus in both modes.
// - in peripheral mode a high read/write input enables the data drivers.
// - after reset rises, six cycles pass, mask sets, restart vector loads.
`timescale 1ns/1ps
`default_nettype none
`include "cibc_map.svh"

module cibc_top
  import cibc_pkg::*;
#(
  parameter bit          LOCK_OPTION = 1'b1,
  parameter int unsigned QUARTER     = `CIBC_QUARTER_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        reset_in_n,
  input  wire logic        irq_line_a_in,
  output wire logic        irq_line_a_oe,
  input  wire logic        irq_line_b_in,
  output wire logic        irq_line_b_oe,
  input  wire logic        nmi_in_n,
  input  wire logic        ready_in,
  input  wire logic        bus_direction_en,
  input  wire logic        external_rom_select,
  input  wire logic [15:0] addr_in,
  output var  logic [15:0] addr_out,
  output var  logic        addr_oe,
  input  wire logic [7:0]  data_in,
  output var  logic [7:0]  data_out,
  output var  logic        data_oe,
  input  wire logic        rw_in,
  output var  logic        rw_out,
  output var  logic        rw_oe,
  output var  logic        bus_pull_low,
  output wire logic        phase2_out,
  output wire logic        phase4_out,
  output var  logic        port_d_line_two,
  input  wire logic        bus_tristate_ctl,
  input  wire logic        port_d_gpio_out,
  input  wire logic        row_rx_irq_src,
  input  wire logic        timer_irq_src,
  input  wire logic [15:0] core_addr,
  input  wire logic [7:0]  core_wdata,
  input  wire logic        core_rw,
  input  wire logic        core_sync,
  input  wire logic        core_rmw_cycle,
  input  wire logic        core_brk,
  input  wire logic [15:0] core_pc,
  input  wire logic [7:0]  core_status,
  input  wire logic [7:0]  core_sp,
  input  wire logic        core_imask,
  output var  logic        core_step,
  output var  logic [7:0]  core_rdata,
  output var  logic        core_pc_load,
  output var  logic [15:0] core_pc_value,
  output var  logic        core_imask_set,
  output var  logic        test_mode,
  output var  logic [15:0] int_addr,
  output var  logic [7:0]  int_wdata,
  output var  logic        int_re,
  output var  logic        int_we,
  output var  logic        int_sel_rom,
  output var  logic        int_sel_ram,
  output var  logic        int_sel_io,
  input  wire logic [7:0]  int_rdata
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: every asynchronous pin passes two flops first

  localparam int unsigned PW = 32;

  logic [PW-1:0] pin_meta_ff;
  logic [PW-1:0] pin_sync_ff;

  wire [PW-1:0] pin_raw = {reset_in_n, irq_line_a_in, irq_line_b_in, nmi_in_n, ready_in,
                           bus_direction_en, rw_in, external_rom_select, addr_in, data_in};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // reset view holds the pin in reset and the rom select off, so no false start-up
      pin_meta_ff <= 32'h7EFF_0000;
      pin_sync_ff <= 32'h7EFF_0000;
    end else begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  wire        rst_s   = pin_sync_ff[31];
  wire        irq_a_s = pin_sync_ff[30];
  wire        irq_b_s = pin_sync_ff[29];
  wire        nmi_n_s = pin_sync_ff[28];
  wire        ready_s = pin_sync_ff[27];
  wire        be_s    = pin_sync_ff[26];
  wire        rw_s    = pin_sync_ff[25];
  wire        rsel_s  = pin_sync_ff[24];
  wire [15:0] addr_s  = pin_sync_ff[23:8];
  wire [7:0]  data_s  = pin_sync_ff[7:0];

  ////////////////////////////////////////////////////////////////////////////////
  // phase clocks and interrupt lines

  logic          cycle_end;
  logic          phase2_rise;
  logic          nmi_taken;
  cibc_irq_req_t irq_req;
  logic [15:0]   mask_vec;

  cibc_phase_gen #(
    .QUARTER (QUARTER)
  ) u_phase (
    .clk         (clk),
    .reset_n     (reset_n),
    .phase2_ff   (phase2_out),
    .phase4_ff   (phase4_out),
    .cycle_end   (cycle_end),
    .phase2_rise (phase2_rise)
  );

  cibc_irq_ctl u_irq (
    .clk           (clk),
    .reset_n       (reset_n),
    .irq_a_level   (irq_a_s),
    .irq_b_level   (irq_b_s),
    .nmi_level_n   (nmi_n_s),
    .row_rx_src    (row_rx_irq_src),
    .timer_src     (timer_irq_src),
    .nmi_taken     (nmi_taken),
    .irq_line_a_oe (irq_line_a_oe),
    .irq_line_b_oe (irq_line_b_oe),
    .req           (irq_req),
    .mask_vec      (mask_vec)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer state and decode

  cibc_state_t state_ff;
  cibc_state_t nxt_state;
  logic [2:0]  init_cnt_ff;
  logic [2:0]  nxt_init_cnt;
  logic [15:0] vec_ff;
  logic [15:0] nxt_vec;
  logic [15:0] pc_save_ff;
  logic [7:0]  psr_save_ff;
  logic [7:0]  vec_lo_ff;
  logic        stall_ff;
  logic        cap_pend_ff;

  wire in_run  = (state_ff == ST_RUN);
  wire in_push = (state_ff == ST_PUSH_PCH) || (state_ff == ST_PUSH_PCL) ||
                 (state_ff == ST_PUSH_PSR);
  wire in_vec  = (state_ff == ST_VEC_LO) || (state_ff == ST_VEC_HI);
  wire active  = in_run || in_push || in_vec;
  wire periph  = active && !be_s;

  // a halted cycle keeps its address and data, since nothing below moves on
  wire cyc_adv = cycle_end && !stall_ff && be_s && active;
  wire per_adv = cycle_end && periph;

  // break ignores the mask; the non-maskable edge wins over both
  wire irq_ok   = (irq_req.row || irq_req.ext || irq_req.tmr) && !core_imask;
  wire take     = cyc_adv && in_run && core_sync &&
                  (irq_req.nmi || core_brk || irq_ok);
  wire [15:0] take_vec = irq_req.nmi ? `CIBC_VEC_NMI :
                         core_brk    ? `CIBC_VEC_BRK : mask_vec;
  assign nmi_taken = take && irq_req.nmi;

  wire [7:0] sp_addr = (state_ff == ST_PUSH_PCL) ? 8'(core_sp - 8'h01) :
                       (state_ff == ST_PUSH_PSR) ? 8'(core_sp - 8'h02) : core_sp;
  wire [7:0] push_byte = (state_ff == ST_PUSH_PCH) ? pc_save_ff[15:8] :
                         (state_ff == ST_PUSH_PCL) ? pc_save_ff[7:0] : psr_save_ff;
  wire [15:0] vec_addr = (state_ff == ST_VEC_HI) ? (vec_ff | `CIBC_VEC_HI_BIT) : vec_ff;

  cibc_cycle_t norm_cyc;
  assign norm_cyc.addr  = in_push ? {`CIBC_STACK_PAGE, sp_addr} :
                          in_vec  ? vec_addr : core_addr;
  assign norm_cyc.wdata = in_push ? push_byte : core_wdata;
  assign norm_cyc.rw    = in_push ? 1'b0 : (in_vec ? 1'b1 : core_rw);

  // peripheral cycles come from the synchronised pins of the outside master
  wire [15:0] cyc_addr = periph ? addr_s : norm_cyc.addr;
  wire        cyc_rw   = periph ? rw_s : norm_cyc.rw;
  wire [7:0]  cyc_wdat = periph ? data_s : norm_cyc.wdata;

  wire rom_ext = test_mode && rsel_s;
  wire rom_hit = (cyc_addr >= `CIBC_ROM_BASE) && !rom_ext;
  wire ram_hit = ((cyc_addr & `CIBC_RAM_MASK) == `CIBC_RAM_BASE);
  wire io_hit  = ((cyc_addr & `CIBC_IO_MASK) == `CIBC_IO_BASE);
  wire int_hit = rom_hit || ram_hit || io_hit;
  wire [7:0] rd_byte = int_hit ? int_rdata : data_s;

  // the three-state bit has no effect in test mode
  wire bus_drive = be_s && (!bus_tristate_ctl || test_mode);
  wire bus_pull  = be_s && bus_tristate_ctl && !test_mode;
  wire lock_n    = !(in_run && be_s && core_rmw_cycle);

  always_comb begin
    nxt_state    = state_ff;
    nxt_init_cnt = init_cnt_ff;
    nxt_vec      = vec_ff;
    if (!rst_s) begin
      nxt_state = ST_RESET;
    end else begin
      case (state_ff)
        ST_RESET: begin
          nxt_state    = ST_INIT;
          nxt_init_cnt = 3'h0;
        end
        ST_INIT: begin
          if (cycle_end) begin
            if (init_cnt_ff == 3'(`CIBC_INIT_CYCLES - 3'h1)) begin
              nxt_state = ST_VEC_LO;
              nxt_vec   = `CIBC_VEC_RST;
            end else begin
              nxt_init_cnt = 3'(init_cnt_ff + 3'h1);
            end
          end
        end
        ST_RUN: begin
          if (take) begin
            nxt_state = ST_PUSH_PCH;
            nxt_vec   = take_vec;
          end
        end
        ST_PUSH_PCH: nxt_state = cyc_adv ? ST_PUSH_PCL : ST_PUSH_PCH;
        ST_PUSH_PCL: nxt_state = cyc_adv ? ST_PUSH_PSR : ST_PUSH_PCL;
        ST_PUSH_PSR: nxt_state = cyc_adv ? ST_VEC_LO : ST_PUSH_PSR;
        ST_VEC_LO:   nxt_state = cyc_adv ? ST_VEC_HI : ST_VEC_LO;
        ST_VEC_HI:   nxt_state = cyc_adv ? ST_RUN : ST_VEC_HI;
        default:     nxt_state = ST_RESET;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer registers

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff    <= ST_RESET;
      init_cnt_ff <= 3'h0;
      vec_ff      <= `CIBC_VEC_RST;
      pc_save_ff  <= 16'h0000;
      psr_save_ff <= 8'h00;
      vec_lo_ff   <= 8'h00;
    end else begin
      state_ff    <= nxt_state;
      init_cnt_ff <= nxt_init_cnt;
      vec_ff      <= nxt_vec;
      if (take) begin
        pc_save_ff  <= core_pc;
        psr_save_ff <= core_brk && !irq_req.nmi ? (core_status | `CIBC_BRK_FLAG) : core_status;
      end
      if (cyc_adv && state_ff == ST_VEC_LO) begin
        vec_lo_ff <= rd_byte;
      end
    end
  end

  // ready is sampled as phase two rises, so its value from the low phase decides
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stall_ff <= 1'b0;
    end else if (phase2_rise && !ready_s) begin
      stall_ff <= 1'b1;
    end else if (ready_s) begin
      stall_ff <= 1'b0;
    end
  end

  // the mode strap is taken one clock after release, while bus enable must still hold
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_pend_ff <= 1'b0;
      test_mode   <= 1'b0;
    end else begin
      cap_pend_ff <= (state_ff == ST_RESET) && rst_s;
      if (cap_pend_ff) begin
        test_mode <= !be_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // core handshake

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_step      <= 1'b0;
      core_rdata     <= 8'h00;
      core_pc_load   <= 1'b0;
      core_pc_value  <= 16'h0000;
      core_imask_set <= 1'b0;
    end else begin
      core_step      <= cyc_adv && in_run && !take;
      core_pc_load   <= cyc_adv && (state_ff == ST_VEC_HI);
      core_imask_set <= cyc_adv && (state_ff == ST_VEC_HI);
      if (cyc_adv) begin
        core_rdata <= rd_byte;
      end
      if (cyc_adv && state_ff == ST_VEC_HI) begin
        core_pc_value <= {rd_byte, vec_lo_ff};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // external pins and internal memory strobes

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_out        <= 16'h0000;
      addr_oe         <= 1'b0;
      data_out        <= 8'h00;
      data_oe         <= 1'b0;
      rw_out          <= 1'b1;
      rw_oe           <= 1'b0;
      bus_pull_low    <= 1'b0;
      port_d_line_two <= 1'b1;
    end else begin
      addr_out        <= norm_cyc.addr;
      addr_oe         <= bus_drive;
      rw_out          <= norm_cyc.rw;
      rw_oe           <= bus_drive;
      bus_pull_low    <= bus_pull;
      data_out        <= periph ? int_rdata : norm_cyc.wdata;
      data_oe         <= periph ? (rw_s && phase2_out) :
                         (bus_drive && active && !norm_cyc.rw && phase2_out);
      port_d_line_two <= LOCK_OPTION ? lock_n : port_d_gpio_out;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_addr    <= 16'h0000;
      int_wdata   <= 8'h00;
      int_re      <= 1'b0;
      int_we      <= 1'b0;
      int_sel_rom <= 1'b0;
      int_sel_ram <= 1'b0;
      int_sel_io  <= 1'b0;
    end else begin
      int_addr    <= cyc_addr;
      int_wdata   <= cyc_wdat;
      int_re      <= active && cyc_rw && int_hit;
      int_we      <= (cyc_adv || per_adv) && !cyc_rw && int_hit;
      int_sel_rom <= active && rom_hit;
      int_sel_ram <= active && ram_hit;
      int_sel_io  <= active && io_hit;
    end
  end

endmodule
`default_nettype wire

// ==== verification/cibc_top_sva.sv ====
// concurrent checks on the interrupt and bus control pins
`timescale 1ns/1ps
`default_nettype none
module cibc_top_sva
  import cibc_pkg::*;
#(
  parameter int unsigned QUARTER = 50
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic core_rmw_cycle,
  input wire logic port_d_line_two,
  input wire logic timer_irq_src,
  input wire logic row_rx_irq_src,
  input wire logic irq_line_a_oe,
  input wire logic irq_line_b_oe,
  input wire logic bus_pull_low,
  input wire logic addr_oe,
  input wire logic data_oe,
  input wire logic rw_oe,
  input wire logic phase2_out,
  input wire logic phase4_out,
  input wire logic core_pc_load,
  input wire logic core_imask_set,
  input wire logic core_step
);
  logic [15:0]      p2_cnt_ff;
  wire logic [15:0] nxt_p2_cnt;
  // phase two width is a parameter, so it is counted rather than repeated
  assign nxt_p2_cnt = phase2_out ? p2_cnt_ff + 16'h0001 : 16'h0000;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) p2_cnt_ff <= 16'h0000;
    else p2_cnt_ff <= nxt_p2_cnt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence p2_rise;
    $rose(phase2_out);
  endsequence
  sequence vec_done;
    core_pc_load ##0 core_imask_set ##0 !core_step;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  lock_cause_a: assert property (!port_d_line_two |-> $past(core_rmw_cycle))
    else $error("lock low without modify cycle");
  timer_pull_a: assert property (timer_irq_src && !row_rx_irq_src |=>
    irq_line_a_oe && !irq_line_b_oe) else $error("timer source pull wrong");
  row_pull_a: assert property (row_rx_irq_src |=> irq_line_a_oe && irq_line_b_oe)
    else $error("row source pull wrong");
  line_idle_a: assert property (!timer_irq_src && !row_rx_irq_src |=>
    !irq_line_a_oe && !irq_line_b_oe) else $error("request line pulled without source");
  pull_nodrive_a: assert property (bus_pull_low |-> !addr_oe && !data_oe && !rw_oe)
    else $error("bus driven while pulled low");
  rw_dir_a: assert property (rw_oe == addr_oe)
    else $error("read write direction differs from address");
  phase_lead_a: assert property (p2_rise |-> $past(phase4_out))
    else $error("phase four not leading phase two");
  phase_len_a: assert property ($fell(phase2_out) |-> p2_cnt_ff == 2 * QUARTER)
    else $error("phase two width wrong");
  vec_entry_a: assert property (core_pc_load |-> vec_done)
    else $error("vector load without mask set");
endmodule
bind cibc_top cibc_top_sva #(.QUARTER(QUARTER)) u_sva (.clk, .reset_n, .core_rmw_cycle,
  .port_d_line_two, .timer_irq_src, .row_rx_irq_src, .irq_line_a_oe, .irq_line_b_oe,
  .bus_pull_low, .addr_oe, .data_oe, .rw_oe, .phase2_out, .phase4_out, .core_pc_load,
  .core_imask_set, .core_step);
`default_nettype wire

// ==== verification/cibc_ext_mem.sv ====
// external memory on the far side of the bus: answers reads, logs writes
`timescale 1ns/1ps
`default_nettype none
module cibc_ext_mem
  import cibc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        addr_oe,
  input  wire logic        rw_out,
  input  wire logic        data_oe,
  input  wire logic        bus_pull_low,
  input  wire logic        phase2_out,
  input  wire logic [15:0] addr_out,
  input  wire logic [7:0]  data_out,
  output var  logic [7:0]  data_in
);
  logic [23:0] wq[$];
  logic [23:0] cap_ff;
  logic        held_ff = 1'b0;
  logic [7:0]  last_ff = 8'h00;
  // released bus toggles every cycle so a stale value never looks valid
  always_comb data_in = bus_pull_low ? 8'h00 : (addr_oe && rw_out) ? addr_out[7:0] ^ 8'h3c
    : ~last_ff;
  always @(posedge clk) begin
    last_ff <= data_in;
    if (phase2_out && data_oe && !rw_out) begin
      cap_ff <= {addr_out, data_out};
      held_ff <= 1'b1;
    end else if (held_ff) begin
      wq.push_back(cap_ff);
      held_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// testbench: reset start-up, interrupt entry, stall, lock and three-state behaviour
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cibc_pkg::*;
;
  logic clk, reset_n, reset_in_n, nmi_in_n, ready_in, bus_direction_en, bus_tristate_ctl;
  logic row_rx_irq_src, timer_irq_src, ext_b, core_rmw_cycle, core_brk, core_imask;
  logic [15:0] core_pc, core_addr = 16'h0000;
  logic [7:0] core_status, core_sp, core_wdata = 8'h00;
  logic port_d_gpio_out = 1'b0;
  logic rw_pin = 1'b1;
  logic rom_sel = 1'b0;
  wire logic irq_line_a_oe, irq_line_b_oe, addr_oe, data_oe, rw_out, rw_oe, bus_pull_low;
  wire logic phase2_out, phase4_out, port_d_line_two, test_mode;
  // variables, not nets, so that count_for can take them by reference
  logic core_step, core_pc_load;
  wire logic [15:0] addr_out, core_pc_value, int_addr;
  wire logic [7:0] data_out, data_in, int_rdata;
  wire logic irq_line_a_in = !irq_line_a_oe;
  wire logic irq_line_b_in = !(irq_line_b_oe | ext_b);
  logic [15:0] vec [5] = '{16'hfff8, 16'hfffa, 16'hfffc, 16'hffec, 16'hfffe};
  int seed = 32'he36e;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  assign int_rdata = int_addr[7:0] ^ 8'h5a;
  cibc_top #(.QUARTER(2)) u_cibc_top (.clk, .reset_n, .reset_in_n, .irq_line_a_in,
    .irq_line_a_oe, .irq_line_b_in, .irq_line_b_oe, .nmi_in_n, .ready_in, .bus_direction_en,
    .external_rom_select(rom_sel), .addr_in(16'h0000), .addr_out, .addr_oe, .data_in, .data_out,
    .data_oe, .rw_in(rw_pin), .rw_out, .rw_oe, .bus_pull_low, .phase2_out, .phase4_out,
    .port_d_line_two, .bus_tristate_ctl, .port_d_gpio_out, .row_rx_irq_src, .timer_irq_src,
    .core_addr, .core_wdata, .core_rw(1'b1), .core_sync(1'b1), .core_rmw_cycle, .core_brk,
    .core_pc, .core_status, .core_sp, .core_imask, .core_step, .core_rdata(), .core_pc_load,
    .core_pc_value, .core_imask_set(), .test_mode, .int_addr, .int_wdata(), .int_re(),
    .int_we(), .int_sel_rom(), .int_sel_ram(), .int_sel_io(), .int_rdata);
  cibc_ext_mem u_cibc_ext_mem (.clk, .addr_oe, .rw_out, .data_oe, .bus_pull_low, .phase2_out,
    .addr_out, .data_out, .data_in);
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) begin
    core_addr <= 16'($random(seed));
    core_wdata <= 8'($random(seed));
    port_d_gpio_out <= 1'($random(seed));
    rw_pin <= 1'($random(seed));
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      miscompares++;
      report_and_stop;
    end
  end
  function automatic logic [7:0] f(input logic [15:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // samples at the falling edge, where the one-cycle pulse has settled
  task automatic wait_pc;
    int i;
    for (i = 0; i < 800 && core_pc_load !== 1'b1; i++) @(negedge clk);
    if (i == 800) check("vector load wait", 0, 1);
  endtask
  task automatic count_for(input int c, ref logic s, output int n);
    n = 0;
    repeat (c) @(negedge clk) n += (s === 1'b1);
  endtask
  // k: 0 row, 1 external, 2 timer, 3 non-maskable, 4 break
  task automatic run_case(input int k);
    int n;
    @(negedge clk);
    core_pc = 16'($random(seed));
    core_sp = 8'($random(seed)) | 8'h08;
    core_status = 8'($random(seed));
    u_cibc_ext_mem.wq.delete();
    row_rx_irq_src = (k == 0);
    ext_b = (k == 1);
    timer_irq_src = (k == 2);
    if (k < 3) begin
      count_for(60, core_pc_load, n);
      check("masked entries", n, 0);
    end
    core_imask = (k >= 3);
    nmi_in_n = (k != 3);
    core_brk = (k == 4);
    wait_pc;
    check("vector", core_pc_value, {f(vec[k] | 16'h0001), f(vec[k])});
    {row_rx_irq_src, ext_b, timer_irq_src, core_brk, core_imask} = 5'b0_0001;
    check("push pc high", u_cibc_ext_mem.wq[0], {8'h01, core_sp, core_pc[15:8]});
    check("push pc low", u_cibc_ext_mem.wq[1], {8'h01, core_sp - 8'h01, core_pc[7:0]});
    check("push status", u_cibc_ext_mem.wq[2], {8'h01, core_sp - 8'h02,
      core_status | (k == 4 ? 8'h10 : 8'h00)});
    count_for(60, core_pc_load, n);
    check("repeat entries", n, 0);
    nmi_in_n = 1'b1;
    $display("interrupt case %0d done", k);
  endtask
  initial begin
    int n;
    {reset_n, reset_in_n, nmi_in_n, ready_in, bus_direction_en} = 5'b0_0111;
    {bus_tristate_ctl, row_rx_irq_src, timer_irq_src, ext_b} = 4'h0;
    {core_rmw_cycle, core_brk, core_imask} = 3'b001;
    core_pc = 16'h0000;
    core_status = 8'h00;
    core_sp = 8'hf0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    reset_in_n = 1'b1;
    wait_pc;
    check("restart vector", core_pc_value, {f(16'hffef), f(16'hffee)});
    check("test mode", test_mode, 0);
    $display("reset test done");
    for (int k = 0; k < 5; k++) run_case(k);
    ready_in = 1'b0;
    count_for(40, core_step, n);
    check("stalled steps", n <= 1, 1);
    ready_in = 1'b1;
    count_for(40, core_step, n);
    check("resumed steps", n >= 4, 1);
    core_rmw_cycle = 1'b1;
    repeat (3) @(negedge clk);
    check("lock low", port_d_line_two, 0);
    core_rmw_cycle = 1'b0;
    bus_tristate_ctl = 1'b1;
    repeat (3) @(negedge clk);
    check("lock high", port_d_line_two, 1);
    check("pull and drive", {bus_pull_low, addr_oe}, 2'b10);
    bus_tristate_ctl = 1'b0;
    repeat (3) @(negedge clk);
    check("drive again", {bus_pull_low, addr_oe}, 2'b01);
    $display("stall, lock and pull tests done");
    // restart in mid-run with bus enable strapped low, then fetch the vector outside
    reset_in_n = 1'b0;
    bus_direction_en = 1'b0;
    repeat (6) @(negedge clk);
    reset_in_n = 1'b1;
    repeat (6) @(negedge clk);
    {bus_direction_en, rom_sel} = 2'b11;
    wait_pc;
    check("strapped test mode", test_mode, 1);
    check("external restart", core_pc_value, {8'hef ^ 8'h3c, 8'hee ^ 8'h3c});
    $display("test mode test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
